//--- rtl/irs_regs.vh
// Constants for the infrared serial encoder/decoder.
//
// Summary of operation
// RULE1 - Enabled codec encodes transmit, decodes receive.
// RULE2 - Link is half-duplex, never both directions.
// RULE3 - Bit timing comes from UART baud generator.
// RULE4 - Software enables UART before using codec.
// RULE5 - Bit spans 16 baud clocks; one stays low.
// RULE6 - Zero: low 7, high 3, low 6.
// RULE7 - Software clears receive enable while transmitting.
// RULE8 - Decoded data passes only with receive enable.
// RULE9 - Software keeps UART silent while receiving.
// RULE10 - Input idle full bit gives high.
// RULE11 - Valid pulse gives delayed low receive bit.
// RULE12 - Pulses wider than five baud clocks discarded.
// RULE13 - Minimum check only when field non-zero.
// RULE14 - Six-bit down-counter loads field then 2'b11.
// RULE15 - Accept pulse at least count clocks wide.
// RULE16 - Zero field uses plain edge detection.
// RULE17 - Software derives field from clock and width.
// RULE18 - Only first received bit may jitter.
// RULE19 - Software sets both shared pins to mode 7.
// RULE20 - Software disables modem-status interrupt.
// RULE21 - Echo test inverts transmit into receive.
// RULE22 - Receive enable clear ignores infrared input.
// RULE23 - Infrared input synchronised by two flops.
`ifndef IRS_REGS_VH
`define IRS_REGS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define IRS_ADDR_W 8
`define IRS_CTRL_OFFS 8'hbf
`define IRS_STAT_OFFS 8'hc0
`define IRS_CTRL_RESET 8'h00
`define IRS_CTRL_WMASK 8'hf7

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define IRS_EN_BIT 0
`define IRS_RXEN_BIT 1
`define IRS_ECHO_BIT 2
`define IRS_MINP_HI 7
`define IRS_MINP_LO 4

// ----------------------------------------------------------------
// Bit timing in baud clocks; minimum-pulse low bits in core clocks
// ----------------------------------------------------------------
`define IRS_BIT_TICKS 16
`define IRS_TX_HI_START 7
`define IRS_TX_HI_END 10
`define IRS_RX_MAX_TICKS 5
`define IRS_MINP_LOW_BITS 2'h3

`endif

//--- rtl/irs_sync.v
// Two-stage synchroniser for a single level.
`timescale 1ns/100ps
`default_nettype none

module irs_sync
(
    input wire core_clk,
    input wire rstn,
    input wire d_in,
    output wire q_out
);

    reg s1_r;
    reg s2_r;

    // The decoder feeds the inverted line, whose idle level is low, so both stages reset low.
    always @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
        end
        else
        begin
            s1_r <= d_in; // RULE23
            s2_r <= s1_r;
        end
    end

    assign q_out = s2_r;

endmodule // irs_sync

`default_nettype wire

//--- rtl/irs_encoder.v
// Transmit encoder: one UART zero bit of 16 baud ticks to an infrared pulse.
`timescale 1ns/100ps
`default_nettype none
`include "irs_regs.vh"

module irs_encoder
(
    input wire core_clk,
    input wire rstn,
    input wire enable,
    input wire baud_tick,
    input wire uart_txd,
    output wire tx_pulse
);

    reg [3:0] phase_r;
    reg bit_r;
    reg pulse_r;

    localparam integer HI_FIRST = `IRS_TX_HI_START - 1;
    localparam integer HI_LAST = `IRS_TX_HI_END - 1;
    localparam [3:0] HI_FIRST_PH = HI_FIRST[3:0];
    localparam [3:0] HI_LAST_PH = HI_LAST[3:0];

    // The bit level is latched at phase 0 so a transmit edge mid-bit cannot chop the pulse.
    always @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            phase_r <= 4'h0;
            bit_r <= 1'b1;
            pulse_r <= 1'b0;
        end
        else if (!enable)
        begin
            phase_r <= 4'h0;
            bit_r <= 1'b1;
            pulse_r <= 1'b0;
        end
        else if (baud_tick)
        begin
            if (phase_r == 4'h0 && uart_txd)
            begin
                // Idle line stays in phase 0 so each new start bit aligns.
                bit_r <= 1'b1;
                pulse_r <= 1'b0; // RULE5
            end
            else
            begin
                phase_r <= phase_r + 4'h1; // RULE5
                if (phase_r == 4'h0)
                    bit_r <= uart_txd;
                if (phase_r == HI_FIRST_PH)
                    pulse_r <= ~((phase_r == 4'h0) ? uart_txd : bit_r); // RULE6
                else if (phase_r == HI_LAST_PH)
                    pulse_r <= 1'b0; // RULE6
            end
        end
    end

    assign tx_pulse = pulse_r;

endmodule // irs_encoder

`default_nettype wire

//--- rtl/irs_endec.v
// Infrared serial encoder/decoder top level with its control register.
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "irs_regs.vh"

module irs_endec
(
    input wire core_clk,
    input wire rstn,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire baud_tick,
    input wire uart_txd,
    output wire uart_rxd,
    output wire infrared_tx_out,
    input wire infrared_rx_in
);

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    reg [7:0] infrared_control_reg;
    wire codec_enable_bit = infrared_control_reg[`IRS_EN_BIT];
    wire infrared_receive_enable = infrared_control_reg[`IRS_RXEN_BIT];
    wire echo_bit = infrared_control_reg[`IRS_ECHO_BIT];
    wire [3:0] min_pulse = infrared_control_reg[`IRS_MINP_HI:`IRS_MINP_LO];
    wire tx_pulse;
    wire rx_sync;
    reg rxd_r;
    reg pulse_seen_r;
    reg [3:0] rx_phase_r;
    reg rx_active_r;
    reg [3:0] width_r;
    reg [5:0] down_r;
    reg min_ok_r;
    reg rx_prev_r;
    reg too_wide_r;
    reg [7:0] reg_rdata_nxt;

    localparam integer RX_MAX = `IRS_RX_MAX_TICKS;
    localparam integer BIT_LAST = `IRS_BIT_TICKS - 1;
    localparam [3:0] RX_MAX_W = RX_MAX[3:0];
    localparam [3:0] BIT_LAST_PH = BIT_LAST[3:0];

    always @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            infrared_control_reg <= `IRS_CTRL_RESET;
        else if (reg_wr && reg_addr == `IRS_CTRL_OFFS)
            infrared_control_reg <= reg_wdata & `IRS_CTRL_WMASK;
    end

    always @*
    begin
        reg_rdata_nxt = 8'h00;
        if (reg_addr == `IRS_CTRL_OFFS)
            reg_rdata_nxt = infrared_control_reg;
        else if (reg_addr == `IRS_STAT_OFFS)
            reg_rdata_nxt = {4'h0, rx_active_r, rx_sync, rxd_r, tx_pulse};
    end

    always @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= reg_rdata_nxt;
        else
            reg_rdata <= 8'h00;
    end

    // ----------------------------------------------------------------
    // Transmit path
    // ----------------------------------------------------------------
    irs_encoder u_enc
    (
        .core_clk(core_clk),
        .rstn(rstn),
        .enable(codec_enable_bit), // RULE1
        .baud_tick(baud_tick), // RULE3
        .uart_txd(uart_txd),
        .tx_pulse(tx_pulse)
    );

    // While echo testing, the pin is held idle so nothing leaves the chip.
    assign infrared_tx_out = codec_enable_bit & ~echo_bit & tx_pulse;

    // ----------------------------------------------------------------
    // Receive path
    // ----------------------------------------------------------------
    // The echo path inverts the encoder output; software must keep receive disabled
    // while the UART sends, since the decoder does not arbitrate direction itself.
    wire rx_src = echo_bit ? ~tx_pulse : infrared_rx_in; // RULE21 RULE2

    // The line idles high and a light pulse pulls it low, so the decoder works on its inverse.
    irs_sync u_sync
    (
        .core_clk(core_clk),
        .rstn(rstn),
        .d_in(~rx_src), // RULE10
        .q_out(rx_sync)
    );

    wire rx_on = codec_enable_bit & infrared_receive_enable; // RULE22
    wire rise = rx_sync & ~rx_prev_r;
    wire fall = ~rx_sync & rx_prev_r;
    wire min_pass = (min_pulse == 4'h0) | min_ok_r | (down_r == 6'h01); // RULE13 RULE16
    wire pulse_valid = fall & ~too_wide_r & min_pass; // RULE15

    // Pulse width: baud ticks for the upper bound, core clocks for the lower.
    always @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_prev_r <= 1'b0;
            width_r <= 4'h0;
            too_wide_r <= 1'b0;
            down_r <= 6'h00;
            min_ok_r <= 1'b0;
        end
        else
        begin
            rx_prev_r <= rx_sync;
            if (rise)
            begin
                // A tick on the rising edge already lies inside the pulse.
                width_r <= {3'b000, baud_tick}; // RULE12
                too_wide_r <= 1'b0;
                down_r <= {min_pulse, `IRS_MINP_LOW_BITS}; // RULE14
                min_ok_r <= 1'b0;
            end
            else if (rx_sync)
            begin
                if (baud_tick && width_r != 4'hf)
                    width_r <= width_r + 4'h1;
                if (baud_tick && width_r >= RX_MAX_W)
                    too_wide_r <= 1'b1; // RULE12
                if (down_r != 6'h00)
                    down_r <= down_r - 6'h01; // RULE14
                if (down_r == 6'h01)
                    min_ok_r <= 1'b1; // RULE15
            end
        end
    end

    // A valid pulse starts a fixed 16-tick low bit; pulses arriving mid-bit are
    // kept for the next bit, so only the first bit carries sampling jitter.
    always @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rxd_r <= 1'b1;
            rx_phase_r <= 4'h0;
            rx_active_r <= 1'b0;
            pulse_seen_r <= 1'b0;
        end
        else if (!rx_on)
        begin
            rxd_r <= 1'b1; // RULE8
            rx_phase_r <= 4'h0;
            rx_active_r <= 1'b0;
            pulse_seen_r <= 1'b0;
        end
        else
        begin
            if (pulse_valid)
                pulse_seen_r <= 1'b1; // RULE11
            if (baud_tick)
            begin
                if (!rx_active_r)
                begin
                    if (pulse_seen_r || pulse_valid)
                    begin
                        rx_active_r <= 1'b1;
                        rxd_r <= 1'b0; // RULE11
                        rx_phase_r <= 4'h0;
                        pulse_seen_r <= 1'b0;
                    end
                end
                else if (rx_phase_r == BIT_LAST_PH)
                begin
                    rx_phase_r <= 4'h0; // RULE18
                    rxd_r <= ~(pulse_seen_r | pulse_valid); // RULE10
                    rx_active_r <= pulse_seen_r | pulse_valid;
                    pulse_seen_r <= 1'b0;
                end
                else
                    rx_phase_r <= rx_phase_r + 4'h1; // RULE5
            end
        end
    end

    assign uart_rxd = rxd_r;

endmodule // irs_endec

`default_nettype wire

//--- sim/irs_endec_chk.sv
// Port-level assertion checker for the infrared encoder/decoder.
`timescale 1ns/100ps
`default_nettype none
`include "irs_regs.vh"

module irs_endec_chk
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic baud_tick,
    input wire logic uart_txd,
    input wire logic uart_rxd,
    input wire logic infrared_tx_out,
    input wire logic infrared_rx_in
);
default clocking @(posedge core_clk); endclocking
default disable iff (!rstn);
// ----------------------------------------------------------------
// Mirror, cycle and tick counters
// ----------------------------------------------------------------
logic [7:0] ctl_r;
logic [7:0] off_r;
logic [5:0] hi_r;
logic [5:0] lo_r;
always @(posedge core_clk or negedge rstn)
    if (!rstn)
    begin
        ctl_r <= 8'h00;
        off_r <= 8'h00;
        hi_r <= 6'h00;
        lo_r <= 6'h00;
    end
    else
    begin
        if (reg_wr && reg_addr == `IRS_CTRL_OFFS)
            ctl_r <= reg_wdata & `IRS_CTRL_WMASK;
        off_r <= (ctl_r[1:0] == 2'h3) ? 8'h00 : off_r + {7'h00, off_r != 8'hff};
        hi_r <= !infrared_tx_out ? 6'h00 : hi_r + {5'h00, baud_tick};
        lo_r <= uart_rxd ? 6'h00 : lo_r + {5'h00, baud_tick};
    end
// ----------------------------------------------------------------
// Properties
// ----------------------------------------------------------------
property p_tx3;
    $fell(infrared_tx_out) |-> hi_r == 6'h03;
endproperty
a_tx3: assert property (p_tx3) else $error("tx pulse width wrong");
property p_rxlen;
    $rose(uart_rxd) |-> lo_r[3:0] == 4'h0 && lo_r != 6'h00;
endproperty
a_rxlen: assert property (p_rxlen) else $error("rx low not 16 ticks");
property p_rxfall;
    $fell(uart_rxd) |-> $past(baud_tick);
endproperty
a_rxfall: assert property (p_rxfall) else $error("rx fell off tick");
// Clearing an enable forces the receive line high a clock later; the idle check still waits 100 cycles.
property p_rxoff;
    off_r > 8'h64 |-> uart_rxd;
endproperty
a_rxoff: assert property (p_rxoff) else $error("rx active while off");
property p_echo;
    ctl_r[2] |-> !infrared_tx_out;
endproperty
a_echo: assert property (p_echo) else $error("pin active in echo");
property p_en;
    !ctl_r[0] |-> !infrared_tx_out;
endproperty
a_en: assert property (p_en) else $error("pin active while off");
property p_rdz;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
endproperty
a_rdz: assert property (p_rdz) else $error("read data not idle");
property p_rdctl;
    $past(reg_rd) && $past(reg_addr) == `IRS_CTRL_OFFS |-> reg_rdata == $past(ctl_r);
endproperty
a_rdctl: assert property (p_rdctl) else $error("control read wrong");
c_tx: cover property ($fell(infrared_tx_out));
c_rx: cover property ($fell(uart_rxd));
c_rd: cover property (reg_rd && reg_addr == `IRS_CTRL_OFFS);
endmodule // irs_endec_chk

bind irs_endec irs_endec_chk chk_u (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .baud_tick(baud_tick), .uart_txd(uart_txd), .uart_rxd(uart_rxd),
    .infrared_tx_out(infrared_tx_out), .infrared_rx_in(infrared_rx_in));
`default_nettype wire

//--- sim/irs_xcvr.sv
// Infrared transceiver model: one light pulse of a set width on command.
`timescale 1ns/100ps
`default_nettype none

module irs_xcvr
(
    input wire logic core_clk,
    input wire logic go,
    input wire logic [7:0] wid,
    output wire logic ir
);
logic [7:0] cnt_r = 8'h00;
// Sends only when told, so the bench keeps the link one way at a time.
always @(posedge core_clk)
    cnt_r <= go ? wid : cnt_r - {7'h00, cnt_r != 8'h00};
// The line idles high and is pulled low for the length of the pulse.
assign ir = cnt_r == 8'h00;
endmodule // irs_xcvr
`default_nettype wire

//--- sim/test_irs_endec.sv
// Self-checking testbench for the infrared encoder/decoder.
`timescale 1ns/100ps
`default_nettype none
`include "irs_regs.vh"

module test_irs_endec;
logic core_clk, rstn, reg_wr, reg_rd, baud_tick, uart_txd, go;
logic [7:0] reg_addr, reg_wdata, wid, ph;
wire [7:0] reg_rdata;
wire uart_rxd, infrared_tx_out, infrared_rx_in;
int error_cnt, tests_run, cyc, lo_n, hi_n;
irs_endec dut_u (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .baud_tick(baud_tick),
    .uart_txd(uart_txd), .uart_rxd(uart_rxd), .infrared_tx_out(infrared_tx_out),
    .infrared_rx_in(infrared_rx_in));
irs_xcvr xcvr_u (.core_clk(core_clk), .go(go), .wid(wid), .ir(infrared_rx_in));
initial
begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
end
// ----------------------------------------------------------------
// Baud ticks every 4 clocks, tick counters and timeout
// ----------------------------------------------------------------
always @(posedge core_clk)
begin
    ph <= ph + 8'h01;
    baud_tick <= ph[1:0] == 2'h3;
    cyc <= cyc + 1;
    if (baud_tick && uart_rxd === 1'b0)
        lo_n <= lo_n + 1;
    if (baud_tick && infrared_tx_out === 1'b1)
        hi_n <= hi_n + 1;
    if (cyc == 60000)
    begin
        error_cnt++;
        print_verdict();
    end
end
task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
        $display("Error at %0t: got %h expected %h", $time, got, exp);
    if (got !== exp)
        error_cnt++;
endtask
task automatic tk(input int n);
    repeat (n * 4) @(posedge core_clk);
endtask
task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
endtask
task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
endtask
// ----------------------------------------------------------------
// Scenarios
// ----------------------------------------------------------------
task automatic t_regs;
    rd(`IRS_CTRL_OFFS, 8'h00);
    wr(`IRS_CTRL_OFFS, 8'hff);
    rd(`IRS_CTRL_OFFS, 8'hf7);
    wr(8'h10, 8'h5a);
    rd(8'h10, 8'h00);
    rd(`IRS_STAT_OFFS, 8'h02);
endtask
// Bits go out first to last from the low end, each held 16 ticks.
task automatic t_tx(input logic [7:0] c, input logic [2:0] b, input logic [7:0] eh, input logic [7:0] el);
    int sh, sl;
    wr(`IRS_CTRL_OFFS, c);
    sh = hi_n;
    sl = lo_n;
    for (int i = 0; i < 3; i++)
    begin
        uart_txd <= b[i];
        tk(16);
    end
    uart_txd <= 1'b1;
    tk(24);
    chk(8'(hi_n - sh), eh);
    chk(8'(lo_n - sl), el);
endtask
task automatic t_rx(input logic [7:0] c, input logic [7:0] w, input int n, input logic [7:0] e);
    int s;
    wr(`IRS_CTRL_OFFS, c);
    s = lo_n;
    repeat (n)
    begin
        go <= 1'b1;
        wid <= w;
        @(posedge core_clk);
        go <= 1'b0;
        tk(16);
    end
    tk(24);
    chk(8'(lo_n - s), e);
endtask
task automatic print_verdict;
    $display("Errors %0d, checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
        $display("Run complete: PASS");
    else
        $display("Run complete: FAIL");
    $finish;
endtask
initial
begin
    {rstn, reg_wr, reg_rd, baud_tick, go, reg_addr, reg_wdata, wid, ph} = '0;
    {error_cnt, tests_run, cyc, lo_n, hi_n} = '0;
    uart_txd = 1'b1;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    t_regs();
    t_tx(8'h01, 3'b100, 8'h06, 8'h00);
    t_tx(8'h01, 3'b111, 8'h00, 8'h00);
    t_tx(8'h00, 3'b000, 8'h00, 8'h00);
    t_tx(8'h07, 3'b110, 8'h00, 8'h10);
    t_rx(8'h03, 8'h08, 1, 8'h10);
    t_rx(8'h03, 8'h08, 2, 8'h20);
    t_rx(8'h03, 8'h14, 1, 8'h10);
    t_rx(8'h03, 8'h18, 1, 8'h00);
    t_rx(8'h01, 8'h08, 1, 8'h00);
    t_rx(8'h03, 8'h01, 1, 8'h10);
    t_rx(8'h23, 8'h0b, 1, 8'h10);
    t_rx(8'h23, 8'h0a, 1, 8'h00);
    print_verdict();
end
endmodule // test_irs_endec
`default_nettype wire
